/* File: fault_interrupt_and_write_lock.sv */
// Fault status, interrupt mask, write lock and system configuration registers.
// Assumes fault inputs are synchronous to aclk and a single AXI4-Lite master.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns

// Contract
// - Bit 7 follows LED supply overvoltage
// - Bit 6 follows six volt rail fault
// - Bit 4 regulator fault; STANDBY, clear enable
// - Bit 2 low supply warning only
// - Bit 1 thermal shutdown; STANDBY, enable kept
// - Bit 0 die overtemperature warning only
// - Status register read-only, all eight bits
// - Mask bit one blocks its interrupt
// - Mask bit zero lets flag interrupt
// - Writing zero key locks again
// - Key read gives lock state, not data
// - Protected registers readable whatever the lock state; every read gives zero in RESET
// - Config layout: reserved zeros, program, map
// - Key register resets locked
// - Map bit selects switch mapping
module fault_interrupt_and_write_lock #(
  parameter int UNDERVOLTAGE_LOCKOUT_FLAG_DELAY = fault_irq_pkg::UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [fault_irq_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [fault_irq_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire fault_irq_pkg::fault_inputs_type fault_inputs,
  output logic interrupt_out_n,
  output logic display_regulator_enable,
  output logic nvm_commit_control,
  output logic switch_map_select,
  output fault_irq_pkg::device_mode_type device_mode
);
  import fault_irq_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] status_r;
  logic [7:0] mask_r;
  logic [7:0] config_r;
  logic enable_r;
  logic enable_nxt;
  key_state_type key_r;
  key_state_type key_nxt;
  device_mode_type mode_r;
  device_mode_type mode_nxt;
  logic [UNDERVOLTAGE_LOCKOUT_FLAG_CNT_W-1:0] undervoltage_lockout_flag_cnt_r;
  logic undervoltage_lockout_flag_expired_r;
  logic irq_n_r;
  logic awready_r;
  logic wready_r;
  logic arready_r;
  logic [5:0] wr_idx_r;
  logic [7:0] wr_data_r;
  logic wr_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Ready low with no response pending means that item is held
  wire aw_take = awvalid && awready_r;
  wire w_take = wvalid && wready_r;
  wire wr_fire = !awready_r && !wready_r && !bvalid_r;
  wire ar_take = arvalid && arready_r;
  wire port_on = (mode_r != MODE_RESET);
  wire wr_is_status = (wr_idx_r == FAULT_STATUS_IDX);
  wire wr_is_mask = (wr_idx_r == FAULT_MASK_IDX);
  wire wr_is_key = (wr_idx_r == WRITE_UNLOCK_KEY_IDX);
  wire wr_is_cfg = (wr_idx_r == SYSTEM_CONFIG_IDX);
  wire wr_is_ctrl = (wr_idx_r == REGULATOR_CONTROL_IDX);
  wire wr_mapped = wr_is_status || wr_is_mask || wr_is_key || wr_is_cfg || wr_is_ctrl;
  // AXI4-Lite port is dead in RESET: writes are answered but have no effect
  wire wr_ok = wr_fire && wr_mapped && port_on && wr_lane_r;
  wire unlocked = (key_r == KEY_OPEN);
  wire [5:0] rd_idx = araddr[7:2];
  wire rd_is_status = (rd_idx == FAULT_STATUS_IDX);
  wire rd_is_mask = (rd_idx == FAULT_MASK_IDX);
  wire rd_is_key = (rd_idx == WRITE_UNLOCK_KEY_IDX);
  wire rd_is_cfg = (rd_idx == SYSTEM_CONFIG_IDX);
  wire rd_is_ctrl = (rd_idx == REGULATOR_CONTROL_IDX);
  wire rd_mapped = rd_is_status || rd_is_mask || rd_is_key || rd_is_cfg || rd_is_ctrl;
  wire [7:0] key_view = unlocked ? KEY_READ_OPEN : KEY_READ_LOCKED;
  // Protected registers read the same whatever the lock state
  wire [7:0] rd_byte = !port_on ? 8'h00 :
                       rd_is_status ? status_r :
                       rd_is_mask ? mask_r :
                       rd_is_key ? key_view :
                       rd_is_cfg ? (config_r & CFG_WRITE_MASK) :
                       rd_is_ctrl ? {7'h00, enable_r} : 8'h00;
  wire [7:0] fault_vec = {fault_inputs.led_supply_overvoltage,
                          fault_inputs.six_volt_rail_fault,
                          !fault_inputs.projector_on_request_n,
                          fault_inputs.display_regulator_fault,
                          fault_inputs.undervoltage_lockout,
                          fault_inputs.supply_low_warning,
                          fault_inputs.thermal_shutdown,
                          fault_inputs.die_overtemp_warning};
  wire irq_nxt = |(status_r & ~mask_r);
  wire undervoltage_lockout_flag_done = (undervoltage_lockout_flag_cnt_r == UNDERVOLTAGE_LOCKOUT_FLAG_CNT_W'(UNDERVOLTAGE_LOCKOUT_FLAG_DELAY - 1));

  // ****************************************************************
  // Write lock sequence
  // ****************************************************************
  always_comb begin
    key_nxt = key_r;
    if (wr_ok && wr_is_key) begin
      if (wr_data_r == KEY_LOCK) begin
        key_nxt = KEY_LOCKED;
      end else begin
        case (key_r)
          KEY_LOCKED: key_nxt = (wr_data_r == KEY_FIRST) ? KEY_ARMED : KEY_LOCKED;
          // Second byte must come right after the first
          KEY_ARMED: key_nxt = (wr_data_r == KEY_SECOND) ? KEY_OPEN : KEY_LOCKED;
          KEY_OPEN: key_nxt = KEY_OPEN;
          default: key_nxt = KEY_LOCKED;
        endcase
      end
    end else if (wr_ok && key_r == KEY_ARMED) begin
      key_nxt = KEY_LOCKED;
    end
  end

  // ****************************************************************
  // Regulator enable and operating mode
  // ****************************************************************
  always_comb begin
    enable_nxt = enable_r;
    if (wr_ok && wr_is_ctrl && unlocked) begin
      enable_nxt = wr_data_r[0];
    end
    // Hardware fault wins over a software set in the same cycle
    if (status_r[STAT_DISPLAY_BIT] || status_r[STAT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT]) begin
      enable_nxt = 1'b0;
    end
  end

  always_comb begin
    case (1'b1)
      undervoltage_lockout_flag_expired_r: mode_nxt = MODE_RESET;
      status_r[5]: mode_nxt = MODE_OFF;
      status_r[4]: mode_nxt = MODE_STANDBY;
      status_r[1]: mode_nxt = MODE_STANDBY;
      default: mode_nxt = MODE_NORMAL;
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= STATUS_RESET;
      irq_n_r <= 1'b1;
    end else begin
      // Live flags, no software write path
      status_r <= fault_vec;
      irq_n_r <= !irq_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RESET;
      config_r <= CFG_RESET;
      key_r <= KEY_LOCKED;
      enable_r <= 1'b0;
    end else begin
      if (wr_ok && wr_is_mask) begin
        mask_r <= wr_data_r;
      end
      // Reserved bit 1 is stored as written; host keeps it zero
      if (wr_ok && wr_is_cfg && unlocked) begin
        config_r <= wr_data_r & CFG_WRITE_MASK;
      end
      key_r <= key_nxt;
      enable_r <= enable_nxt;
    end
  end

  // Counts only while undervoltage persists; a dropout restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      undervoltage_lockout_flag_cnt_r <= '0;
      undervoltage_lockout_flag_expired_r <= 1'b0;
      mode_r <= MODE_NORMAL;
    end else begin
      if (!status_r[STAT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT]) begin
        undervoltage_lockout_flag_cnt_r <= '0;
        undervoltage_lockout_flag_expired_r <= 1'b0;
      end else if (!undervoltage_lockout_flag_expired_r) begin
        undervoltage_lockout_flag_cnt_r <= undervoltage_lockout_flag_cnt_r + UNDERVOLTAGE_LOCKOUT_FLAG_CNT_W'(1);
        undervoltage_lockout_flag_expired_r <= undervoltage_lockout_flag_done;
      end
      mode_r <= mode_nxt;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      wr_idx_r <= 6'h00;
      wr_data_r <= 8'h00;
      wr_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_r <= 1'b0;
        wr_idx_r <= awaddr[7:2];
      end
      if (w_take) begin
        wready_r <= 1'b0;
        wr_data_r <= wdata[7:0];
        wr_lane_r <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      arready_r <= 1'b0;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign interrupt_out_n = irq_n_r;
  assign display_regulator_enable = enable_r;
  assign nvm_commit_control = config_r[CFG_NVM_BIT];
  assign switch_map_select = config_r[CFG_MAP_BIT];
  assign device_mode = mode_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_key_write(logic [7:0] val);
    wr_ok && wr_is_key && wr_data_r == val;
  endsequence

  sequence s_open_after;
    ##1 key_r == KEY_OPEN;
  endsequence

  property p_status_follow;
    1 |-> ##1 status_r == $past(fault_vec);
  endproperty
  a_status_follow: assert property (p_status_follow) else $error("status not tracking inputs");

  property p_irq_assert;
    (|(status_r & ~mask_r)) |-> ##1 !interrupt_out_n;
  endproperty
  a_irq_assert: assert property (p_irq_assert) else $error("pin not pulled for unmasked flag");

  property p_irq_masked;
    (status_r & ~mask_r) == 8'h00 |-> ##1 interrupt_out_n;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked flag drove the pin");

  property p_unlock;
    (key_r == KEY_ARMED) and s_key_write(KEY_SECOND) |-> s_open_after;
  endproperty
  a_unlock: assert property (p_unlock) else $error("second key byte did not unlock");

  property p_lock;
    s_key_write(KEY_LOCK) |-> ##1 key_r == KEY_LOCKED;
  endproperty
  a_lock: assert property (p_lock) else $error("zero key did not lock");

  property p_abandon;
    key_r == KEY_ARMED && wr_ok && !(wr_is_key && wr_data_r == KEY_SECOND)
      |-> ##1 key_r == KEY_LOCKED;
  endproperty
  a_abandon: assert property (p_abandon) else $error("broken sequence left lock armed");

  property p_key_read;
    ar_take && rd_is_key && port_on |-> ##1 rdata[7:0] == ($past(unlocked) ? 8'h01 : 8'h00);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read wrong lock state");

  property p_fault_enable;
    status_r[STAT_DISPLAY_BIT] |-> ##1 !display_regulator_enable && device_mode != MODE_NORMAL;
  endproperty
  a_fault_enable: assert property (p_fault_enable) else $error("regulator fault kept enable");

  property p_tsd_keeps;
    status_r[1] && !status_r[STAT_DISPLAY_BIT] && !status_r[STAT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT]
      && !(wr_ok && wr_is_ctrl) |-> ##1 $stable(display_regulator_enable);
  endproperty
  a_tsd_keeps: assert property (p_tsd_keeps) else $error("thermal shutdown changed enable");

  property p_undervoltage_lockout_flag_expire;
    status_r[STAT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT] && undervoltage_lockout_flag_done && !undervoltage_lockout_flag_expired_r |-> ##2 device_mode == MODE_RESET;
  endproperty
  a_undervoltage_lockout_flag_expire: assert property (p_undervoltage_lockout_flag_expire) else $error("no RESET after delay");

  property p_cfg_reserved;
    rvalid && $rose(rvalid) |-> rdata[7:3] == 5'h00 || !$past(rd_is_cfg);
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved config bits nonzero");

endmodule

/* File: fault_irq_pkg.sv */
// Constants, types and register map for the fault interrupt and write lock block.
// Assumes a 50 MHz system clock and AXI4-Lite register access with 8-bit addresses.
package fault_irq_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_MS = 25;
  localparam int UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_CYCLES = UNDERVOLTAGE_LOCKOUT_FLAG_DELAY_MS * (CLK_HZ / 1000);
  localparam int UNDERVOLTAGE_LOCKOUT_FLAG_CNT_W = 21;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam int AXI_ADDR_W = 8;
  localparam logic [5:0] FAULT_STATUS_IDX = 6'h0C;
  localparam logic [5:0] FAULT_MASK_IDX = 6'h0D;
  localparam logic [5:0] WRITE_UNLOCK_KEY_IDX = 6'h10;
  localparam logic [5:0] SYSTEM_CONFIG_IDX = 6'h11;
  localparam logic [5:0] REGULATOR_CONTROL_IDX = 6'h12;

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam int STAT_UNDERVOLTAGE_LOCKOUT_FLAG_BIT = 3;
  localparam int STAT_DISPLAY_BIT = 4;
  localparam int CFG_NVM_BIT = 2;
  localparam int CFG_MAP_BIT = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h07;
  localparam logic [7:0] KEY_FIRST = 8'hBA;
  localparam logic [7:0] KEY_SECOND = 8'hBE;
  localparam logic [7:0] KEY_LOCK = 8'h00;
  localparam logic [7:0] KEY_READ_LOCKED = 8'h00;
  localparam logic [7:0] KEY_READ_OPEN = 8'h01;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic led_supply_overvoltage;
    logic six_volt_rail_fault;
    logic projector_on_request_n;
    logic display_regulator_fault;
    logic undervoltage_lockout;
    logic supply_low_warning;
    logic thermal_shutdown;
    logic die_overtemp_warning;
  } fault_inputs_type;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_STANDBY = 4'b0010,
    MODE_OFF = 4'b0100,
    MODE_RESET = 4'b1000
  } device_mode_type;

  typedef enum logic [2:0] {
    KEY_LOCKED = 3'b001,
    KEY_ARMED = 3'b010,
    KEY_OPEN = 3'b100
  } key_state_type;

endpackage

/* File: display_controller_model.sv */
// Behavioural display controller that watches the active-low interrupt line.
// Assumes the line is a registered level from the block, synchronous to aclk.
`timescale 1ns/1ns
module display_controller_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic interrupt_out_n,
  output logic [7:0] fall_cnt
);
  // ****************************************************************
  // Interrupt watch
  // ****************************************************************
  logic line_r;
  // Only a high-to-low step is a new request, a held low is not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_r <= 1'b1;
      fall_cnt <= 8'h00;
    end else begin
      line_r <= interrupt_out_n;
      if (line_r && !interrupt_out_n) begin
        fall_cnt <= fall_cnt + 8'h01;
      end
    end
  end
endmodule

/* File: tb_fault_interrupt_and_write_lock.sv */
// Self-checking bench for the fault interrupt and write lock block.
// Assumes an AXI4-Lite master in the bench and the controller model beside it.
`timescale 1ns/1ns
module tb_fault_interrupt_and_write_lock;
  import fault_irq_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int UD = 20;
  localparam logic [7:0] ST_A = {FAULT_STATUS_IDX, 2'b00};
  localparam logic [7:0] MK_A = {FAULT_MASK_IDX, 2'b00};
  localparam logic [7:0] KY_A = {WRITE_UNLOCK_KEY_IDX, 2'b00};
  localparam logic [7:0] CF_A = {SYSTEM_CONFIG_IDX, 2'b00};
  localparam logic [7:0] RG_A = {REGULATOR_CONTROL_IDX, 2'b00};
  localparam logic [7:0] IDLE = 8'h20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] strb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq_n, reg_en, nvm, map;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  logic [7:0] fall_cnt;
  device_mode_type mode;
  fault_inputs_type fi = IDLE;
  int error_cnt = 0;
  int n_checks = 0;
  int b;
  always #10 aclk = ~aclk;
  fault_interrupt_and_write_lock #(.UNDERVOLTAGE_LOCKOUT_FLAG_DELAY(UD)) dut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .fault_inputs(fi),
    .interrupt_out_n(irq_n), .display_regulator_enable(reg_en),
    .nvm_commit_control(nvm), .switch_map_select(map), .device_mode(mode));
  display_controller_model pc (.aclk, .aresetn, .interrupt_out_n(irq_n), .fall_cnt);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= {24'h0, d};
    wstrb <= strb; bready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        done = 1'b1; rsp = bresp; bready <= 1'b0;
      end
    end
    if (!done) error_cnt++;
  endtask
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        done = 1'b1; rd_v = rdata; rsp = rresp; rready <= 1'b0;
      end
    end
    if (!done) error_cnt++;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_v, e);
  endtask
  // Input at edge N shows on the pin at N+2; three edges leave margin
  task automatic setf(input logic [7:0] v);
    @(posedge aclk);
    fi <= v;
    repeat (3) @(posedge aclk);
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    #200000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rc(MK_A, MASK_RESET);
    rc(KY_A, KEY_READ_LOCKED);
    rc(CF_A, CFG_RESET);
    rc(ST_A, 0);
    chk(irq_n, 1);
    $display("end of reset test");
    // One flag at a time; undervoltage cleared long before its delay runs out
    for (b = 0; b < 8; b++) begin
      setf((8'h01 << b) ^ IDLE);
      rc(ST_A, 32'h1 << b);
      chk(irq_n, 0);
      chk(mode, b == 5 ? MODE_OFF : (b == 4 || b == 1) ? MODE_STANDBY : MODE_NORMAL);
      setf(IDLE);
      chk(irq_n, 1);
    end
    chk(fall_cnt, 8);
    $display("end of flag test");
    setf(8'hD7);
    wr(MK_A, 8'hFF);
    repeat (2) @(posedge aclk);
    chk(irq_n, 1);
    wr(MK_A, 8'hFE);
    repeat (2) @(posedge aclk);
    chk(irq_n, 0);
    rc(MK_A, 8'hFE);
    wr(ST_A, 8'h00);
    rc(ST_A, 8'hF7);
    wr(MK_A, 8'h00);
    // Byte lane 0 not strobed: the write must leave the mask alone
    strb = 4'h0;
    wr(MK_A, 8'h55);
    strb = 4'hF;
    rc(MK_A, MASK_RESET);
    setf(IDLE);
    $display("end of mask test");
    wr(CF_A, 8'h05);
    rc(CF_A, 0);
    wr(KY_A, KEY_FIRST);
    wr(KY_A, KEY_SECOND);
    rc(KY_A, KEY_READ_OPEN);
    wr(CF_A, 8'hFD);
    rc(CF_A, 8'h05);
    chk(map, 1);
    chk(nvm, 1);
    wr(CF_A, 8'h00);
    chk(nvm, 0);
    chk(map, 0);
    wr(RG_A, 8'h01);
    chk(reg_en, 1);
    setf(8'h22);
    chk(reg_en, 1);
    setf(8'h30);
    chk(reg_en, 0);
    setf(IDLE);
    wr(KY_A, KEY_LOCK);
    rc(KY_A, KEY_READ_LOCKED);
    wr(CF_A, 8'h01);
    rc(CF_A, 0);
    $display("end of lock test");
    wr(KY_A, KEY_FIRST);
    wr(MK_A, 8'h00);
    wr(KY_A, KEY_SECOND);
    rc(KY_A, KEY_READ_LOCKED);
    wr(KY_A, KEY_FIRST);
    wr(KY_A, KEY_FIRST);
    wr(KY_A, KEY_SECOND);
    rc(KY_A, KEY_READ_LOCKED);
    wr(8'hFC, 8'h01);
    chk(rsp, RESP_SLVERR);
    rd(8'hFC);
    chk(rsp, RESP_SLVERR);
    $display("end of abort test");
    wr(KY_A, KEY_FIRST);
    wr(KY_A, KEY_SECOND);
    wr(RG_A, 8'h01);
    setf(8'h28);
    chk(reg_en, 0);
    chk(mode, MODE_NORMAL);
    repeat (UD + 3) @(posedge aclk);
    chk(mode, MODE_RESET);
    // Port is dead in this mode, so this mask write must not land
    wr(MK_A, 8'hFF);
    rc(ST_A, 0);
    setf(IDLE);
    // Expiry flag clears one edge after the status bit, mode one edge later
    @(posedge aclk);
    chk(mode, MODE_NORMAL);
    rc(MK_A, MASK_RESET);
    $display("end of undervoltage test");
    final_report;
  end
endmodule
